/* hw/std_defines.vh */
// constants for the security token address decoder
// assumes includer works in 18-bit offsets inside the security space
// Contract
// - security space is 256 KB; all offsets relative to its base.
// - engine blocks reset to hash 0x32000, des 0x34000, aes 0x38000, rc4 0x36000.
// - context offset is base 0x20000 plus 0x10000 plus token shifted left two.
// - context index: des token 5:3, hashing 6:4, rc4 9:7.
// - hash key page offset is base+0x10000+0x3000+index*32.
// - aes context tokens 0x40,0x54,0x68,0x7c,0x90,0xa4 map to 0..5.
// - data offset is base plus token 7:5 shl 8 plus token 4:0 shl 6.
// - multi-block data token addresses first block; blocks consecutive.
// - data page index: aes token 4:0 shl 2, des shl 3, hashing unshifted.
// - rc4 gets source and destination addresses, not page indices; the code gives a single address, rc4_data_addr_q, equal to the data offset.
// - engine offset is base plus token shifted left by 13.
// - engine token 0x8 is null; zero is a valid token.
`ifndef STD_DEFINES_VH
`define STD_DEFINES_VH
`define STD_AW            18
`define STD_SPACE_BYTES   19'h40000
`define STD_SEC_BASE      18'h20000
`define STD_CTX_HALF      18'h10000
`define STD_SECRET_OFF    18'h03000
`define STD_SLOT_SHIFT    13
`define STD_ENG_NULL      5'h08
`define STD_HASH_RST      18'h32000
`define STD_DES_RST       18'h34000
`define STD_AES_RST       18'h38000
`define STD_RC4_RST       18'h36000
`define STD_AES_T0        11'h040
`define STD_AES_T1        11'h054
`define STD_AES_T2        11'h068
`define STD_AES_T3        11'h07c
`define STD_AES_T4        11'h090
`define STD_AES_T5        11'h0a4
`endif

/* hw/std_decoder.v */
// token to offset and index decoder for the security offload unit
// assumes tokens and relocation writes arrive from logic on clk
`timescale 1ns/1ps
`include "std_defines.vh"
module std_decoder (
  input  wire                clk,
  input  wire                reset,
  input  wire [10:0]         ctx_token,
  input  wire [7:0]          data_token,
  input  wire [4:0]          eng_token,
  input  wire                eng_req,
  input  wire                reloc_we,
  input  wire [1:0]          reloc_sel,
  input  wire [`STD_AW-1:0]  reloc_addr,
  output reg  [`STD_AW-1:0]  ctx_offset_q,
  output reg  [2:0]          des_ctx_idx_q,
  output reg  [2:0]          hash_ctx_idx_q,
  output reg  [2:0]          rc4_ctx_idx_q,
  output reg  [`STD_AW-1:0]  secret_offset_q,
  output reg  [2:0]          aes_ctx_idx_q,
  output reg                 aes_ctx_err_q,
  output reg  [`STD_AW-1:0]  data_offset_q,
  output reg  [6:0]          aes_page_idx_q,
  output reg  [7:0]          des_page_idx_q,
  output reg  [4:0]          hash_page_idx_q,
  output reg  [`STD_AW-1:0]  rc4_data_addr_q,
  output reg  [`STD_AW-1:0]  eng_offset_q,
  output reg                 eng_null_q,
  output reg                 eng_access_q,
  output reg  [`STD_AW-1:0]  hash_blk_q,
  output reg  [`STD_AW-1:0]  des_blk_q,
  output reg  [`STD_AW-1:0]  aes_blk_q,
  output reg  [`STD_AW-1:0]  rc4_blk_q
);
  // 18-bit offsets cover exactly the 256 KB space; engine offsets for tokens 0x10 and above wrap modulo 2^18
  reg  [2:0]          aes_idx_d;
  reg                 aes_err_d;
  wire [`STD_AW-1:0]  ctx_off_d;
  wire [`STD_AW-1:0]  sec_off_d;
  wire [`STD_AW-1:0]  dat_off_d;
  wire [`STD_AW-1:0]  eng_off_d;
  wire                null_d;

  assign ctx_off_d = `STD_SEC_BASE + `STD_CTX_HALF + {5'h00, ctx_token, 2'h0};
  assign sec_off_d = `STD_SEC_BASE + `STD_CTX_HALF + `STD_SECRET_OFF
                   + {10'h000, ctx_token[6:4], 5'h00};
  assign dat_off_d = `STD_SEC_BASE + {7'h00, data_token[7:5], 8'h00}
                   + {7'h00, data_token[4:0], 6'h00};
  assign eng_off_d = `STD_SEC_BASE + {eng_token, 13'h0000};
  assign null_d    = (eng_token == `STD_ENG_NULL);

  always @* begin
    aes_idx_d = 3'h0;
    aes_err_d = 1'b0;
    case (ctx_token)
      `STD_AES_T0: aes_idx_d = 3'h0;
      `STD_AES_T1: aes_idx_d = 3'h1;
      `STD_AES_T2: aes_idx_d = 3'h2;
      `STD_AES_T3: aes_idx_d = 3'h3;
      `STD_AES_T4: aes_idx_d = 3'h4;
      `STD_AES_T5: aes_idx_d = 3'h5;
      default:     aes_err_d = 1'b1;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctx_offset_q    <= {`STD_AW{1'b0}};
      des_ctx_idx_q   <= 3'h0;
      hash_ctx_idx_q  <= 3'h0;
      rc4_ctx_idx_q   <= 3'h0;
      secret_offset_q <= {`STD_AW{1'b0}};
      aes_ctx_idx_q   <= 3'h0;
      aes_ctx_err_q   <= 1'b0;
      data_offset_q   <= {`STD_AW{1'b0}};
      aes_page_idx_q  <= 7'h00;
      des_page_idx_q  <= 8'h00;
      hash_page_idx_q <= 5'h00;
      rc4_data_addr_q <= {`STD_AW{1'b0}};
      eng_offset_q    <= {`STD_AW{1'b0}};
      eng_null_q      <= 1'b0;
      eng_access_q    <= 1'b0;
      hash_blk_q      <= `STD_HASH_RST;
      des_blk_q       <= `STD_DES_RST;
      aes_blk_q       <= `STD_AES_RST;
      rc4_blk_q       <= `STD_RC4_RST;
    end else begin
      ctx_offset_q    <= ctx_off_d;
      des_ctx_idx_q   <= ctx_token[5:3];
      hash_ctx_idx_q  <= ctx_token[6:4];
      rc4_ctx_idx_q   <= ctx_token[9:7];
      secret_offset_q <= sec_off_d;
      aes_ctx_idx_q   <= aes_idx_d;
      aes_ctx_err_q   <= aes_err_d;
      data_offset_q   <= dat_off_d;
      aes_page_idx_q  <= {data_token[4:0], 2'h0};
      des_page_idx_q  <= {data_token[4:0], 3'h0};
      hash_page_idx_q <= data_token[4:0];
      rc4_data_addr_q <= dat_off_d;
      eng_offset_q    <= null_d ? {`STD_AW{1'b0}} : eng_off_d;
      eng_null_q      <= null_d;
      eng_access_q    <= eng_req & ~null_d;
      if (reloc_we) begin
        case (reloc_sel)
          2'h0:    hash_blk_q <= reloc_addr;
          2'h1:    des_blk_q  <= reloc_addr;
          2'h2:    aes_blk_q  <= reloc_addr;
          default: rc4_blk_q  <= reloc_addr;
        endcase
      end
    end
  end
endmodule // std_decoder

/* dv/std_decoder_monitor.sv */
// output checks for the token decoder
// assumes outputs registered one cycle after inputs
`timescale 1ns/1ps
module std_decoder_monitor (
  input clk, reset, eng_req, aes_ctx_err_q, eng_null_q, eng_access_q,
  input [10:0] ctx_token,
  input [7:0] data_token,
  input [4:0] eng_token,
  input [17:0] ctx_offset_q, secret_offset_q, data_offset_q, rc4_data_addr_q, eng_offset_q,
  input [2:0] des_ctx_idx_q, hash_ctx_idx_q, rc4_ctx_idx_q,
  input [4:0] hash_page_idx_q
);
  reg v_q;
  // first edge after reset still shows reset values
  always @(posedge clk or posedge reset)
    if (reset) v_q <= 1'b0;
    else v_q <= 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (reset || !v_q);
  property p_ctx; ctx_offset_q == 18'h30000 + {$past(ctx_token), 2'h0}; endproperty
  a_ctx: assert property (p_ctx) else $error("ctx offset");
  property p_sec; secret_offset_q == 18'h33000 + {$past(ctx_token[6:4]), 5'h0}; endproperty
  a_sec: assert property (p_sec) else $error("secret offset");
  property p_err; aes_ctx_err_q != ($past(ctx_token) inside {'h40, 'h54, 'h68, 'h7c, 'h90, 'ha4}); endproperty
  a_err: assert property (p_err) else $error("aes error flag");
  property p_dat; data_offset_q == 18'h20000 + {$past(data_token), 6'h0} + {$past(data_token[7:5]), 8'h0} - {$past(data_token[7:5]), 11'h0}; endproperty
  a_dat: assert property (p_dat) else $error("data offset");
  property p_rc4; rc4_data_addr_q == data_offset_q; endproperty
  a_rc4: assert property (p_rc4) else $error("rc4 address");
  property p_eng; $past(eng_token) != 5'h8 |-> eng_offset_q == 18'h20000 + ($past(eng_token) << 13); endproperty
  a_eng: assert property (p_eng) else $error("engine offset");
  property p_nul; eng_null_q == ($past(eng_token) == 5'h8); endproperty
  a_nul: assert property (p_nul) else $error("null flag");
  property p_acc; eng_access_q == ($past(eng_req) && $past(eng_token) != 5'h8); endproperty
  a_acc: assert property (p_acc) else $error("engine access");
  property p_idx; {des_ctx_idx_q, hash_ctx_idx_q, rc4_ctx_idx_q} == {$past(ctx_token[5:3]), $past(ctx_token[6:4]), $past(ctx_token[9:7])}; endproperty
  a_idx: assert property (p_idx) else $error("context index");
  property p_hpg; hash_page_idx_q == $past(data_token[4:0]); endproperty
  a_hpg: assert property (p_hpg) else $error("hash page index");
endmodule // std_decoder_monitor
bind std_decoder std_decoder_monitor mon (.*);

/* dv/std_sw_model.sv */
// software token source feeding the decoder
// assumes bench steps it just after rising clk
`timescale 1ns/1ps
module std_sw_model (
  input  wire [7:0] blk_tok,
  output wire [7:0] data_token
);
  // multi-block buffer is named by its first block
  assign data_token = blk_tok;
endmodule // std_sw_model

/* dv/test_security_token_address_decoder.sv */
// self-checking bench for the token decoder
// assumes outputs one cycle after inputs
`timescale 1ns/1ps
module test_security_token_address_decoder;
  reg clk = 0, reset = 1, eng_req = 0, reloc_we = 0;
  reg [10:0] ctx_token = 0;
  reg [7:0] blk_tok = 0;
  reg [4:0] eng_token = 0;
  reg [1:0] reloc_sel = 0;
  reg [17:0] reloc_addr = 0;
  wire [17:0] ctx_offset_q, secret_offset_q, data_offset_q, rc4_data_addr_q, eng_offset_q;
  wire [17:0] hash_blk_q, des_blk_q, aes_blk_q, rc4_blk_q;
  wire [2:0] des_ctx_idx_q, hash_ctx_idx_q, rc4_ctx_idx_q, aes_ctx_idx_q;
  wire [7:0] data_token, des_page_idx_q;
  wire [6:0] aes_page_idx_q;
  wire [4:0] hash_page_idx_q;
  wire aes_ctx_err_q, eng_null_q, eng_access_q;
  integer n_mismatch = 0, num_checks = 0, i;
  std_sw_model m (.blk_tok(blk_tok), .data_token(data_token));
  std_decoder DUT (.*);
  initial forever #12.5 clk = ~clk;
  task stp; @(posedge clk); #1; endtask
  task chk(input [31:0] n, input [17:0] e, s);
    num_checks = num_checks + 1;
    if (e !== s) begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL %0s exp %h got %h", n, e, s);
    end
  endtask
  task t_aes;
    for (i = 0; i < 7; i = i + 1) begin
      @(posedge clk) ctx_token <= (i < 6) ? 11'h40 + 11'd20 * i : 11'h41;
      stp;
      chk("aidx", (i < 6) ? i : 0, aes_ctx_idx_q);
      chk("aerr", i == 6, aes_ctx_err_q);
    end
  endtask
  task t_data;
    @(posedge clk) blk_tok <= 8'hff;
    stp;
    chk("doff", 18'h20ec0, data_offset_q);
    chk("dpg", 18'hf8, des_page_idx_q);
    chk("apg", 18'h7c, aes_page_idx_q);
    chk("hpg", 18'h1f, hash_page_idx_q);
    chk("rc4a", 18'h20ec0, rc4_data_addr_q);
  endtask
  task t_ctx;
    @(posedge clk) ctx_token <= 11'h2a8;
    stp;
    chk("coff", 18'h30aa0, ctx_offset_q);
    chk("didx", 18'h5, des_ctx_idx_q);
    chk("hidx", 18'h2, hash_ctx_idx_q);
    chk("ridx", 18'h5, rc4_ctx_idx_q);
    chk("soff", 18'h33040, secret_offset_q);
  endtask
  task t_eng;
    @(posedge clk) eng_req <= 1;
    stp;
    chk("eng0", 18'h20000, eng_offset_q);
    chk("acc0", 1, eng_access_q);
    @(posedge clk) eng_token <= 5'h8;
    stp;
    chk("acc8", 0, eng_access_q);
    chk("nul8", 1, eng_null_q);
  endtask
  task print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 0;
    stp;
    chk("aes", 18'h38000, aes_blk_q);
    t_aes;
    t_ctx;
    t_data;
    t_eng;
    @(posedge clk) reloc_we <= 1;
    reloc_addr <= 18'h3a000;
    stp;
    chk("hblk", 18'h3a000, hash_blk_q);
    @(posedge clk) reloc_sel <= 2'h3;
    reloc_addr <= 18'h3c000;
    stp;
    chk("rblk", 18'h3c000, rc4_blk_q);
    chk("dblk", 18'h34000, des_blk_q);
    @(posedge clk) reloc_we <= 0;
    stp;
    print_verdict;
  end
endmodule // test_security_token_address_decoder
